// ==== core/lin_diag_pkg.sv ====
// lin diagnostic flag package: constants, command codes, status layout, carrier types
// assumes a 100 MHz core clock and at most two lin interfaces
package lin_diag_pkg;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int          LIN_COUNT        = 2;
  localparam int          FRAME_BITS       = 16;
  localparam int          BYTE_BITS        = 8;
  localparam int          RECOVER_FLAGS    = 6;

  // ***************************************************************
  // command decode
  // ***************************************************************
  localparam logic [15:0] CMD_LIN1_FLAG_RD = 16'h2780;
  localparam logic [15:0] CMD_LIN2_FLAG_RD = 16'h2980;
  localparam logic [1:0]  CMD_TYPE_WRITE   = 2'h1;
  localparam int          CMD_TYPE_MSB     = 15;
  localparam int          CMD_TYPE_LSB     = 14;

  // ***************************************************************
  // status byte layout
  // ***************************************************************
  localparam int          FIX_WU_BIT       = 6;
  localparam int          FIX_LIN_G_BIT    = 3;
  localparam int          EXT_LIN1_BIT     = 4;
  localparam int          EXT_LIN2_BIT     = 5;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          T_DOM_NS         = 10000;
  localparam int          DOM_CYCLES       = T_DOM_NS / CLK_PERIOD_NS;
  localparam int          DOM_CNT_W        = 16;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef enum logic {SPI_IDLE, SPI_FRAME} spi_state_t;

  typedef struct packed {
    logic bus_dom;
    logic term_short;
    logic over_temp;
    logic rxd_low;
    logic rxd_high;
    logic txd_dom;
    logic wake_event;
  } lin_cond_t;

  typedef struct packed {
    logic dom_clamp;
    logic trx_state;
    logic wake_rx_state;
    logic wake_src;
    logic term_short;
    logic over_temp;
    logic rxd_low;
    logic rxd_high;
    logic txd_dom;
  } lin_flags_t;

endpackage

// ==== core/lin_sticky_flag.sv ====
// one latched diagnostic flag with clear-on-read
// assumes condition and read strobe are on the core clock
`timescale 1ns/1ps
`default_nettype none
module lin_sticky_flag #(
  parameter bit NEED_RECOVERY = 1'b1
) (
  input  wire logic I_MCLK,
  input  wire logic I_RST,
  input  wire logic i_cond,
  input  wire logic i_read,
  output logic      o_flag
);

  // ***************************************************************
  // flag update: set wins over clear
  // ***************************************************************
  wire logic clear_ok = NEED_RECOVERY ? ~i_cond : 1'b1;
  wire logic next_flag = i_cond | (o_flag & ~(i_read & clear_ok));

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule
`default_nettype wire

// ==== core/lin_diag_status_flags.sv ====
// lin diagnostic flags and spi fixed/extended status response
// assumes spi pins and fault detectors are asynchronous; mode requests are on I_MCLK
//
// Functional notes
// - bus clamp flag sets after dominant timeout; clears after recovery plus read
// - lin state bit is one in transmit/receive mode, zero otherwise
// - state bit drops when the transmit/receive request goes low or on a dominant transmit failure
// - flag-read commands never clear the live lin state bit
// - wake receiver bit is one in sleep with wake enabled and the lin state bit zero; disabled blocks wake
// - flag-read commands leave the wake receiver bit unchanged
// - wake source flag latches on wake event; clears only by a read
// - termination short flag latches; clears after recovery plus read
// - over-temperature flag set while hot; clears once cool and read
// - receive-low flag latches; clears after recovery plus read
// - receive-high flag latches; clears after recovery plus read
// - transmit-dominant flag latches; clears after recovery plus read
// - every spi transfer shifts the fixed status byte out on miso
// - write type 01 returns fixed byte then extended byte
// - other types 00, 10 or 11 return only the fixed byte
`timescale 1ns/1ps
`default_nettype none
module lin_diag_status_flags (
  input  wire logic                                       I_MCLK,
  input  wire logic                                       I_RST,
  input  wire logic                                       I_SCLK,
  input  wire logic                                       I_CS_N,
  input  wire logic                                       I_MOSI,
  output logic                                            O_MISO,
  output logic                                            O_MISO_OE,
  input  wire lin_diag_pkg::lin_cond_t [1:0]              I_LIN_COND,
  input  wire logic [1:0]                                 I_LIN_TRX_REQ,
  input  wire logic [1:0]                                 I_LIN_SLEEP,
  input  wire logic [1:0]                                 I_LIN_WAKE_EN,
  input  wire logic [15:0]                                I_STATUS_OTHER,
  output lin_diag_pkg::lin_flags_t [1:0]                  O_LIN_FLAGS,
  output logic [1:0]                                      O_LIN_WAKEUP,
  output logic                                            O_READ_DONE,
  output logic                                            O_READ_INDEX,
  output lin_diag_pkg::lin_flags_t                        O_READ_FLAGS,
  output logic [15:0]                                     O_CMD_WORD,
  output logic                                            O_CMD_DONE
);

  // ***************************************************************
  // functions
  // ***************************************************************
  function automatic logic is_flag_read(input logic [15:0] word, input int idx);
    logic [15:0] code;
    code = (idx == 0) ? lin_diag_pkg::CMD_LIN1_FLAG_RD : lin_diag_pkg::CMD_LIN2_FLAG_RD;
    return word == code;
  endfunction

  function automatic logic [7:0] or_bit(input logic [7:0] base, input int pos, input logic flag);
    logic [7:0] merged;
    merged      = base;
    merged[pos] = base[pos] | flag;
    return merged;
  endfunction

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam int SYNC_W = 3 + 2 * $bits(lin_diag_pkg::lin_cond_t);
  // chip select idles high in the chain so reset shows no frame edge
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic              sclk_q;
  logic              cs_n_q;

  wire logic [SYNC_W-1:0] raw_in = {I_SCLK, I_CS_N, I_MOSI, I_LIN_COND};

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sync1  <= SYNC_IDLE;
      sync2  <= SYNC_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sync1  <= raw_in;
      sync2  <= sync1;
      sclk_q <= sync2[SYNC_W-1];
      cs_n_q <= sync2[SYNC_W-2];
    end
  end

  wire logic                          sclk_s = sync2[SYNC_W-1];
  wire logic                          cs_n_s = sync2[SYNC_W-2];
  wire logic                          mosi_s = sync2[SYNC_W-3];
  wire lin_diag_pkg::lin_cond_t [1:0] cond_s = sync2[SYNC_W-4:0];

  wire logic sclk_rise = sclk_s & ~sclk_q;
  wire logic sclk_fall = ~sclk_s & sclk_q;
  wire logic cs_start  = ~cs_n_s & cs_n_q;
  wire logic cs_end    = cs_n_s & ~cs_n_q;

  // ***************************************************************
  // spi frame engine
  // ***************************************************************
  lin_diag_pkg::spi_state_t state;
  logic [15:0]              rx_word;
  logic [4:0]               bit_cnt;
  logic [7:0]               tx_shift;
  logic [7:0]               ext_byte;
  logic [7:0]               fix_byte;
  logic                     cmd_done;
  logic [15:0]              cmd_word;

  // ***************************************************************
  // frame decode
  // ***************************************************************
  // the type bits lead the command, so they fill the top of the first byte
  localparam int TYPE_POS = lin_diag_pkg::CMD_TYPE_MSB - lin_diag_pkg::BYTE_BITS;

  wire logic       frame_full = bit_cnt == 5'(lin_diag_pkg::FRAME_BITS);
  wire logic       frame_ok   = cs_end & frame_full;
  wire logic       first_byte = bit_cnt == 5'(lin_diag_pkg::BYTE_BITS);
  wire logic [1:0] cmd_type   = rx_word[TYPE_POS -: 2];
  wire logic       is_write   = cmd_type == lin_diag_pkg::CMD_TYPE_WRITE;
  wire logic [7:0] second     = is_write ? ext_byte : lin_diag_pkg::STATUS_RESET;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state    <= lin_diag_pkg::SPI_IDLE;
      rx_word  <= '0;
      bit_cnt  <= '0;
      tx_shift <= lin_diag_pkg::STATUS_RESET;
      cmd_done <= 1'b0;
      cmd_word <= '0;
    end else begin
      cmd_done <= 1'b0;
      unique case (state)
        lin_diag_pkg::SPI_IDLE: begin
          if (cs_start) begin
            state    <= lin_diag_pkg::SPI_FRAME;
            rx_word  <= '0;
            bit_cnt  <= '0;
            tx_shift <= fix_byte;
          end
        end
        lin_diag_pkg::SPI_FRAME: begin
          if (cs_end) begin
            state    <= lin_diag_pkg::SPI_IDLE;
            cmd_done <= frame_ok;
            cmd_word <= rx_word;
          end else if (sclk_rise && !frame_full) begin
            rx_word <= {rx_word[14:0], mosi_s};
            bit_cnt <= bit_cnt + 5'd1;
          end else if (sclk_fall) begin
            tx_shift <= first_byte ? second : {tx_shift[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // spi outputs
  // ***************************************************************
  assign O_MISO     = tx_shift[7];
  assign O_MISO_OE  = state == lin_diag_pkg::SPI_FRAME;
  assign O_CMD_WORD = cmd_word;
  assign O_CMD_DONE = cmd_done;

  // ***************************************************************
  // per-interface flag sets
  // ***************************************************************
  lin_diag_pkg::lin_flags_t [1:0] flags;
  logic [1:0]                     read_hit;
  logic [1:0]                     any_flag;
  logic [1:0]                     wake_src;

  genvar gi;
  genvar gf;
  generate
    for (gi = 0; gi < lin_diag_pkg::LIN_COUNT; gi++) begin : g_lin
      logic [lin_diag_pkg::DOM_CNT_W-1:0] dom_cnt;
      logic                               trx;
      logic                               req_q;
      logic [lin_diag_pkg::RECOVER_FLAGS-1:0] rec_cond;
      logic [lin_diag_pkg::RECOVER_FLAGS-1:0] rec_flag;

      wire logic dom_timeout = dom_cnt == lin_diag_pkg::DOM_CNT_W'(lin_diag_pkg::DOM_CYCLES);
      wire logic req_rise    = I_LIN_TRX_REQ[gi] & ~req_q;
      wire logic trx_drop    = ~I_LIN_TRX_REQ[gi] | cond_s[gi].txd_dom;
      wire logic wake_rx     = ~trx & I_LIN_SLEEP[gi] & I_LIN_WAKE_EN[gi];
      wire logic wake_hit    = cond_s[gi].wake_event & wake_rx;

      assign read_hit[gi] = cmd_done & is_flag_read(cmd_word, gi);

      always_ff @(posedge I_MCLK) begin
        if (I_RST || !cond_s[gi].bus_dom) begin
          dom_cnt <= '0;
        end else if (!dom_timeout) begin
          dom_cnt <= dom_cnt + 1'b1;
        end
      end

      always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
          trx   <= 1'b0;
          req_q <= 1'b0;
        end else begin
          req_q <= I_LIN_TRX_REQ[gi];
          if (trx_drop) begin
            trx <= 1'b0;
          end else if (req_rise) begin
            trx <= 1'b1;
          end
        end
      end

      assign rec_cond = {dom_timeout, cond_s[gi].term_short, cond_s[gi].over_temp,
                         cond_s[gi].rxd_low, cond_s[gi].rxd_high, cond_s[gi].txd_dom};

      for (gf = 0; gf < lin_diag_pkg::RECOVER_FLAGS; gf++) begin : g_rec
        lin_sticky_flag #(
          .NEED_RECOVERY (1'b1)
        ) u_flag (
          .I_MCLK (I_MCLK),
          .I_RST  (I_RST),
          .i_cond (rec_cond[gf]),
          .i_read (read_hit[gi]),
          .o_flag (rec_flag[gf])
        );
      end

      lin_sticky_flag #(
        .NEED_RECOVERY (1'b0)
      ) u_wake (
        .I_MCLK (I_MCLK),
        .I_RST  (I_RST),
        .i_cond (wake_hit),
        .i_read (read_hit[gi]),
        .o_flag (wake_src[gi])
      );

      // *************************************************************
      // flag outputs
      // *************************************************************
      assign flags[gi].dom_clamp     = rec_flag[5];
      assign flags[gi].term_short    = rec_flag[4];
      assign flags[gi].over_temp     = rec_flag[3];
      assign flags[gi].rxd_low       = rec_flag[2];
      assign flags[gi].rxd_high      = rec_flag[1];
      assign flags[gi].txd_dom       = rec_flag[0];
      assign flags[gi].wake_src      = wake_src[gi];
      assign flags[gi].trx_state     = trx;
      assign flags[gi].wake_rx_state = wake_rx;
      assign any_flag[gi]            = |rec_flag | wake_src[gi];
      assign O_LIN_WAKEUP[gi]        = wake_hit;
    end
  endgenerate

  assign O_LIN_FLAGS = flags;

  // ***************************************************************
  // status bytes
  // ***************************************************************
  wire logic       wake_any  = |wake_src;
  wire logic       lin_any   = |any_flag;
  wire logic [7:0] fix_other = I_STATUS_OTHER[15:8];
  wire logic [7:0] ext_other = I_STATUS_OTHER[7:0];
  wire logic [7:0] fix_wu    = or_bit(fix_other, lin_diag_pkg::FIX_WU_BIT, wake_any);
  wire logic [7:0] ext_lin1  = or_bit(ext_other, lin_diag_pkg::EXT_LIN1_BIT, any_flag[0]);

  assign fix_byte = or_bit(fix_wu, lin_diag_pkg::FIX_LIN_G_BIT, lin_any);
  assign ext_byte = or_bit(ext_lin1, lin_diag_pkg::EXT_LIN2_BIT, any_flag[1]);

  // ***************************************************************
  // read snapshot
  // ***************************************************************
  logic                     read_done;
  logic                     read_index;
  lin_diag_pkg::lin_flags_t read_flags;

  wire logic read_any = |read_hit;
  wire logic read_sel = read_hit[1];

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      read_done <= 1'b0;
    end else begin
      read_done <= read_any;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      read_index <= 1'b0;
      read_flags <= '0;
    end else if (read_any) begin
      read_index <= read_sel;
      read_flags <= read_sel ? flags[1] : flags[0];
    end
  end

  assign O_READ_DONE  = read_done;
  assign O_READ_INDEX = read_index;
  assign O_READ_FLAGS = read_flags;

endmodule
`default_nettype wire

// ==== verif/lin_diag_status_flags_assertions.sv ====
// checker: flag latching, clearing and spi frame timing of the lin flag block
// assumes it sees only the top ports, bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module lin_diag_status_flags_chk (
  input wire logic                          I_MCLK,
  input wire logic                          I_RST,
  input wire logic                          I_CS_N,
  input wire lin_diag_pkg::lin_cond_t [1:0] I_LIN_COND,
  input wire logic [1:0]                    I_LIN_TRX_REQ,
  input wire logic [1:0]                    I_LIN_WAKE_EN,
  input wire logic                          O_MISO_OE,
  input wire lin_diag_pkg::lin_flags_t [1:0] O_LIN_FLAGS,
  input wire logic [1:0]                    O_LIN_WAKEUP,
  input wire logic                          O_READ_DONE,
  input wire logic                          O_READ_INDEX,
  input wire logic [15:0]                   O_CMD_WORD,
  input wire logic                          O_CMD_DONE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // ****************************************
  // helpers and sequences
  // ****************************************
  localparam logic [15:0] DOM = 16'(lin_diag_pkg::DOM_CYCLES);
  logic [15:0] dom_cnt;
  logic [3:0]  txd_hist;
  always_ff @(posedge I_MCLK) begin
    txd_hist <= I_RST ? 4'h0 : {txd_hist[2:0], I_LIN_COND[0].txd_dom};
    if (I_RST || !I_LIN_COND[0].bus_dom) begin
      dom_cnt <= 16'h0000;
    end else if (dom_cnt != 16'hffff) begin
      dom_cnt <= dom_cnt + 16'h0001;
    end
  end
  sequence s_rd(logic idx); O_READ_DONE && (O_READ_INDEX == idx); endsequence
  sequence s_cmd(logic [15:0] w); O_CMD_DONE && (O_CMD_WORD == w); endsequence
  // ****************************************
  // properties
  // ****************************************
  property p_clamp; $rose(O_LIN_FLAGS[0].dom_clamp) |-> dom_cnt >= DOM; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp set early");
  property p_trx_set;
    $rose(I_LIN_TRX_REQ[0]) && !I_LIN_COND[0].txd_dom && !(|txd_hist)
      |=> O_LIN_FLAGS[0].trx_state;
  endproperty
  a_trx_set: assert property (p_trx_set) else $error("state not set");
  property p_trx_drop; !I_LIN_TRX_REQ[0] |=> !O_LIN_FLAGS[0].trx_state; endproperty
  a_trx_drop: assert property (p_trx_drop) else $error("state kept");
  property p_trx_keep;
    $fell(O_LIN_FLAGS[0].trx_state) |-> !$past(I_LIN_TRX_REQ[0]) || (|txd_hist);
  endproperty
  a_trx_keep: assert property (p_trx_keep) else $error("state dropped");
  property p_wake_off;
    !I_LIN_WAKE_EN[1] |-> !O_LIN_FLAGS[1].wake_rx_state && !O_LIN_WAKEUP[1];
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while off");
  property p_wsrc; $fell(O_LIN_FLAGS[1].wake_src) |-> s_rd(1'b1); endproperty
  a_wsrc: assert property (p_wsrc) else $error("wake source lost");
  property p_term; $fell(O_LIN_FLAGS[0].term_short) |-> s_rd(1'b0); endproperty
  a_term: assert property (p_term) else $error("short flag lost");
  property p_temp; I_LIN_COND[0].over_temp [*4] |-> O_LIN_FLAGS[0].over_temp; endproperty
  a_temp: assert property (p_temp) else $error("hot flag missing");
  property p_txd; I_LIN_COND[0].txd_dom [*4] |-> O_LIN_FLAGS[0].txd_dom; endproperty
  a_txd: assert property (p_txd) else $error("transmit flag missing");
  property p_rd1; s_cmd(lin_diag_pkg::CMD_LIN1_FLAG_RD) |=> s_rd(1'b0); endproperty
  a_rd1: assert property (p_rd1) else $error("first read missing");
  property p_rd2; s_cmd(lin_diag_pkg::CMD_LIN2_FLAG_RD) |=> s_rd(1'b1); endproperty
  a_rd2: assert property (p_rd2) else $error("second read missing");
  property p_oe; $fell(I_CS_N) |-> ##[2:5] O_MISO_OE; endproperty
  a_oe: assert property (p_oe) else $error("no answer on frame");
endmodule
bind lin_diag_status_flags lin_diag_status_flags_chk chk_i (
  .I_MCLK, .I_RST, .I_CS_N, .I_LIN_COND, .I_LIN_TRX_REQ, .I_LIN_WAKE_EN, .O_MISO_OE,
  .O_LIN_FLAGS, .O_LIN_WAKEUP, .O_READ_DONE, .O_READ_INDEX, .O_CMD_WORD, .O_CMD_DONE
);
`default_nettype wire

// ==== verif/lin_spi_master.sv ====
// spi master model: mode 0, msb first, 16-bit frames
// assumes clk is the core clock; changes lines at its falling edge
`timescale 1ns/1ps
`default_nettype none
module lin_spi_master (
  input  wire logic clk,
  input  wire logic miso,
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one frame; returns the bits seen on miso
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    gap(8);
    for (int k = 15; k >= 0; k--) begin
      mosi = w[k];
      gap(5);
      sclk = 1'b1;
      r = {r[14:0], miso};
      gap(5);
      sclk = 1'b0;
    end
    gap(5);
    cs_n = 1'b1;
    mosi = ~mosi;
    gap(8);
  endtask
endmodule
`default_nettype wire

// ==== verif/lin_diag_status_flags_test.sv ====
// testbench: lin flag latching, clearing and spi status response
// assumes the spi master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module lin_diag_status_flags_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, mosi, miso, rd_done, rd_idx, cmd_done;
  lin_diag_pkg::lin_cond_t [1:0]  cond = '0;
  lin_diag_pkg::lin_flags_t [1:0] flg;
  lin_diag_pkg::lin_flags_t       rdf;
  logic [1:0]  trx = 2'h0, slp = 2'h0, wen = 2'h0, wk;
  logic [15:0] oth = 16'h0000, lf = 16'hdc28, rx, cmd;
  logic [15:0] q_cmd[$];
  logic [9:0]  q_rd[$];
  int          fail_count = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  lin_diag_status_flags lin_diag_status_flags_i (
    .I_MCLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE(), .I_LIN_COND(cond), .I_LIN_TRX_REQ(trx),
    .I_LIN_SLEEP(slp), .I_LIN_WAKE_EN(wen), .I_STATUS_OTHER(oth), .O_LIN_FLAGS(flg),
    .O_LIN_WAKEUP(wk), .O_READ_DONE(rd_done), .O_READ_INDEX(rd_idx),
    .O_READ_FLAGS(rdf), .O_CMD_WORD(cmd), .O_CMD_DONE(cmd_done));
  lin_spi_master lin_spi_master_i (
    .clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic [15:0] w);
    q_cmd.push_back(w);
    lin_spi_master_i.xfer(w, rx);
    cyc(10);
  endtask
  task automatic rd(input logic i, input lin_diag_pkg::lin_flags_t e);
    q_rd.push_back({i, e});
    send(i ? lin_diag_pkg::CMD_LIN2_FLAG_RD : lin_diag_pkg::CMD_LIN1_FLAG_RD);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // result monitor and watchdog
  // ****************************************
  always @(negedge clk) begin
    if (!rst && cmd_done === 1'b1) begin
      chk(cmd, q_cmd.pop_front());
    end
    if (!rst && rd_done === 1'b1) begin
      chk({6'h00, rd_idx, rdf}, {6'h00, q_rd.pop_front()});
    end
  end
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    cyc(21);
    rst = 1'b0;
    cyc(6);
    chk({flg[0][6:0], flg[1]}, 16'h0000);
    for (int t = 0; t < 4; t++) begin
      lf = nxt(lf);
      oth = lf;
      send({t[1:0], lf[13:0]});
      chk(rx, (t == 1) ? lf : {lf[15:8], 8'h00});
    end
    trx[0] = 1'b1;
    cond[0] = 7'h3c;
    cyc(8);
    cond[0] = 7'h20;
    cyc(4);
    rd(1'b0, 9'h09e);
    chk({7'h00, flg[0]}, 16'h0090);
    chk({7'h00, flg[1]}, 16'h0000);
    cond[0] = 7'h00;
    cyc(4);
    rd(1'b0, 9'h090);
    chk({7'h00, flg[0]}, 16'h0080);
    cond[0].txd_dom = 1'b1;
    cyc(6);
    cond[0].txd_dom = 1'b0;
    cyc(6);
    chk({7'h00, flg[0]}, 16'h0001);
    rd(1'b0, 9'h001);
    trx[0] = 1'b0;
    cyc(2);
    trx[0] = 1'b1;
    cyc(4);
    rd(1'b0, 9'h080);
    chk({7'h00, flg[0]}, 16'h0080);
    trx[0] = 1'b0;
    cyc(2);
    chk({7'h00, flg[0]}, 16'h0000);
    cond[0].bus_dom = 1'b1;
    cyc(990);
    chk({7'h00, flg[0]}, 16'h0000);
    cyc(20);
    rd(1'b0, 9'h100);
    chk({7'h00, flg[0]}, 16'h0100);
    cond[0].bus_dom = 1'b0;
    cyc(4);
    rd(1'b0, 9'h100);
    chk({7'h00, flg[0]}, 16'h0000);
    slp[1] = 1'b1;
    cond[1].wake_event = 1'b1;
    cyc(4);
    cond[1].wake_event = 1'b0;
    cyc(4);
    chk({7'h00, flg[1]}, 16'h0000);
    wen[1] = 1'b1;
    cond[1].wake_event = 1'b1;
    cyc(4);
    chk({14'h0000, wk}, 16'h0002);
    cond[1].wake_event = 1'b0;
    cyc(4);
    rd(1'b1, 9'h060);
    chk({7'h00, flg[1]}, 16'h0040);
    chk(16'(q_cmd.size() + q_rd.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
